// ===== logic/crb_pkg.sv
// Shared constants and types for the configuration readback command decoder
package crb_pkg;
   // Command codes taken from the first byte of a frame
   localparam logic [7:0] CMD_STATUS = 8'h0A;
   localparam logic [7:0] CMD_SEND = 8'h0D;
   localparam logic [7:0] CMD_SEND_RX = 8'h0E;
   localparam logic [7:0] CMD_XTAL_TRIG = 8'h1E;
   localparam logic [7:0] CMD_CONF_TRIG = 8'h1F;
   localparam logic [7:0] CMD_BUF_READ = 8'h20;
   localparam logic [7:0] CMD_FIXED_FREQ = 8'h21;
   localparam logic [7:0] CMD_CHAN_STORE = 8'h22;
   localparam logic [7:0] CMD_CHAN_RESET = 8'h23;
   localparam logic [7:0] CMD_RSSI_ADJ = 8'h24;
   localparam logic [7:0] CMD_CHAN_TRIG = 8'h25;
   // Filler byte on the SPI output
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   // Byte position counter and copy length widths
   localparam int IDX_W = 5;
   localparam logic [IDX_W-1:0] IDX_MAX = 5'h1F;
   localparam logic [IDX_W-1:0] IDX_FIRST_PARAM = 5'h01;
   // Nonvolatile memory layout
   localparam int NVM_AW = 8;
   localparam logic [NVM_AW-1:0] NVM_XTAL_BASE = 8'h00;
   localparam logic [NVM_AW-1:0] NVM_XTAL_FIRST = 8'h02;
   localparam logic [NVM_AW-1:0] NVM_CONF_BASE = 8'h20;
   localparam logic [NVM_AW-1:0] NVM_CHAN_BASE = 8'h30;
   // Readout and channel store lengths in bytes
   localparam logic [IDX_W-1:0] XTAL_LEN = 5'h10;
   localparam logic [IDX_W-1:0] CONF_LEN = 5'h0A;
   localparam logic [IDX_W-1:0] CHAN_STATE_LEN = 5'h01;
   localparam logic [IDX_W-1:0] CHAN_CFG_LEN = 5'h0E;
   // Readout buffer default depth
   localparam int BUF_DEPTH = 16;
   // Channel state byte fields
   localparam logic [3:0] NIBBLE_ONES = 4'hF;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   // Saturation limits of the corrected signal strength
   localparam logic signed [7:0] RSSI_MAX = 8'sh7F;
   localparam logic signed [7:0] RSSI_MIN = -8'sh80;
   // Copy engine states
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WAIT, ST_WR} crb_copy_st_t;
endpackage

// ===== logic/crb_mem.sv
// Readout buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module crb_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_we,
   input wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem_ff [DEPTH];

   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("crb_mem: depth must be at least 2");
   end

   // Storage has no reset, contents survive between frames
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_ff[i_waddr] <= i_wdata;
      end
   end

   // Read data always registered
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem_ff[i_raddr];
      end
   end
endmodule
`default_nettype wire

// ===== logic/crb_spi_link.sv
// SPI slave shifter running on the serial clock
`timescale 1ns/100ps
`default_nettype none
module crb_spi_link import crb_pkg::*; (
   input wire logic i_reset_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   input wire logic [7:0] i_tx_byte,
   output logic [7:0] o_rx_byte,
   output logic o_rx_toggle,
   output logic o_spi_miso
);
   logic frame_rst_n;
   logic [2:0] bit_ff, nxt_bit;
   logic [6:0] sh_in_ff, nxt_sh_in;
   logic [7:0] sh_out_ff, nxt_sh_out;
   logic [7:0] nxt_rx_byte;
   logic nxt_rx_toggle;
   logic byte_done;

   // Frame state cleared while the select is high; the clock may stop then
   assign frame_rst_n = i_reset_n & ~i_spi_cs_n;
   assign byte_done = (bit_ff == 3'h7);

   // Shift in on rising edge; reload output shifter at each byte end
   always_comb begin
      nxt_bit = bit_ff + 3'h1;
      nxt_sh_in = {sh_in_ff[5:0], i_spi_mosi};
      nxt_sh_out = {sh_out_ff[6:0], 1'b0};
      if (byte_done) begin
         nxt_sh_out = i_tx_byte;
      end
   end

   always_ff @(posedge i_spi_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_ff <= '0;
         sh_in_ff <= '0;
         sh_out_ff <= DUMMY_BYTE;
      end else begin
         bit_ff <= nxt_bit;
         sh_in_ff <= nxt_sh_in;
         sh_out_ff <= nxt_sh_out;
      end
   end

   // Completed byte and its event toggle; not reset by select, so no false toggle
   always_comb begin
      nxt_rx_byte = o_rx_byte;
      nxt_rx_toggle = o_rx_toggle;
      if (byte_done && !i_spi_cs_n) begin
         nxt_rx_byte = {sh_in_ff, i_spi_mosi};
         nxt_rx_toggle = ~o_rx_toggle;
      end
   end

   always_ff @(posedge i_spi_sclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rx_byte <= '0;
         o_rx_toggle <= 1'b0;
      end else begin
         o_rx_byte <= nxt_rx_byte;
         o_rx_toggle <= nxt_rx_toggle;
      end
   end

   // Output bit changes on falling edge so the master samples it on rising
   always_ff @(negedge i_spi_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         o_spi_miso <= 1'b0;
      end else begin
         o_spi_miso <= sh_out_ff[7];
      end
   end
endmodule
`default_nettype wire

// ===== logic/crb_top.sv
// Configuration readback, channel maintenance and signal strength command decoder
//
// Summary of operation
// - Crystal trigger copies sixteen coefficients into buffer
// - Config trigger loads frequencies and configuration byte
// - Buffer read returns last triggered buffer contents
// - Crystal readout: sixteen signed bytes after dummy
// - Config readout: ten bytes, frequencies LSB first
// - Channel byte: changed-channel nibble, free count nibble
// - Channel trigger loads current channel state byte
// - Fixed-frequency command toggles hopping versus fixed
// - Reset always selects frequency hopping
// - Channel store writes fourteen bytes to memory
// - Stored signed offset added to measured strength
// - Send commands accepted only after initial configuration
// - Status command clears the pending event
`timescale 1ns/100ps
`default_nettype none
module crb_top import crb_pkg::*; #(
   parameter int BUF_DEPTH_P = BUF_DEPTH,
   parameter logic [3:0] DEFAULT_MACRO_CH = 4'h1
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_nvm_rd,
   output logic [NVM_AW-1:0] o_nvm_rd_addr,
   input wire logic [7:0] i_nvm_rd_data,
   output logic o_nvm_wr,
   output logic [NVM_AW-1:0] o_nvm_wr_addr,
   output logic [7:0] o_nvm_wr_data,
   input wire logic [3:0] i_cur_macro_channel,
   input wire logic [3:0] i_free_micro_channels,
   input wire logic i_init_config_done,
   input wire logic signed [7:0] i_rssi_measured,
   output logic signed [7:0] o_rssi_system,
   output logic o_fixed_freq,
   output logic o_send_frame_req,
   output logic o_send_rx_req,
   output logic o_send_refused,
   output logic o_chan_usage_reset,
   input wire logic i_event_set,
   output logic o_event
);
   localparam int BUF_AW = $clog2(BUF_DEPTH_P);

   if (BUF_DEPTH_P < 16 || BUF_DEPTH_P > 32) begin : g_chk
      $error("crb_top: readout buffer depth must be 16 to 32");
   end

   // Channel state byte: changed-channel nibble over free micro channel count
   function automatic logic [7:0] chan_state(input logic [3:0] cur, input logic [3:0] free_cnt);
      chan_state = {(cur != DEFAULT_MACRO_CH) ? NIBBLE_ONES : NIBBLE_ZERO, free_cnt};
   endfunction

   // Signed add with saturation so a large offset cannot wrap the sign
   function automatic logic signed [7:0] sat_add(input logic signed [7:0] a, input logic signed [7:0] b);
      logic signed [8:0] sum;
      sum = 9'(a) + 9'(b);
      if (sum > 9'(RSSI_MAX)) begin
         sat_add = RSSI_MAX;
      end else if (sum < 9'(RSSI_MIN)) begin
         sat_add = RSSI_MIN;
      end else begin
         sat_add = sum[7:0];
      end
   endfunction

   logic [7:0] link_rx_byte;
   logic link_toggle;
   logic tog_s1_ff, tog_s2_ff, tog_s3_ff;
   logic cs_s1_ff, cs_s2_ff;
   logic byte_ev, frame_idle, is_first;
   logic [7:0] cur_cmd;
   logic [IDX_W-1:0] idx_ff, nxt_idx;
   logic [7:0] cmd_ff, nxt_cmd;
   logic [7:0] tx_hold_ff, nxt_tx_hold;
   logic rd_pend_ff, nxt_rd_pend;
   crb_copy_st_t st_ff, nxt_st;
   logic [NVM_AW-1:0] src_ff, nxt_src;
   logic [IDX_W-1:0] cnt_ff, nxt_cnt;
   logic [IDX_W-1:0] len_ff, nxt_len;
   logic nxt_nvm_rd;
   logic [NVM_AW-1:0] nxt_nvm_rd_addr;
   logic mem_we;
   logic [BUF_AW-1:0] mem_waddr;
   logic [7:0] mem_wdata, mem_rdata;
   logic nxt_nvm_wr;
   logic [NVM_AW-1:0] nxt_nvm_wr_addr;
   logic [7:0] nxt_nvm_wr_data;
   logic signed [7:0] offset_ff, nxt_offset;
   logic signed [7:0] nxt_rssi_system;
   logic nxt_fixed, nxt_send_frame, nxt_send_rx, nxt_refused, nxt_chan_reset;
   logic nxt_event, ev_set, ev_clr;
   logic chan_done, rssi_done;
   logic started_ff;

   // Serial side on its own clock
   crb_spi_link u_link (
      .i_reset_n(i_reset_n),
      .i_spi_sclk(i_spi_sclk),
      .i_spi_cs_n(i_spi_cs_n),
      .i_spi_mosi(i_spi_mosi),
      .i_tx_byte(tx_hold_ff),
      .o_rx_byte(link_rx_byte),
      .o_rx_toggle(link_toggle),
      .o_spi_miso(o_spi_miso)
   );

   // Readout buffer shared by all trigger commands
   crb_mem #(
      .WIDTH(8),
      .DEPTH(BUF_DEPTH_P)
   ) u_buf (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(idx_ff[BUF_AW-1:0]),
      .o_rdata(mem_rdata)
   );

   // Byte toggle and select synchronisers; received byte is stable once toggle seen
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tog_s1_ff <= 1'b0;
         tog_s2_ff <= 1'b0;
         tog_s3_ff <= 1'b0;
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
      end else begin
         tog_s1_ff <= link_toggle;
         tog_s2_ff <= tog_s1_ff;
         tog_s3_ff <= tog_s2_ff;
         cs_s1_ff <= i_spi_cs_n;
         cs_s2_ff <= cs_s1_ff;
      end
   end

   assign byte_ev = tog_s2_ff ^ tog_s3_ff;
   assign frame_idle = cs_s2_ff;
   assign is_first = byte_ev && (idx_ff == '0);
   assign cur_cmd = (idx_ff == '0) ? link_rx_byte : cmd_ff;

   // Byte position within the frame and the latched command
   always_comb begin
      nxt_idx = idx_ff;
      nxt_cmd = cmd_ff;
      if (frame_idle) begin
         nxt_idx = '0;
      end else if (byte_ev) begin
         if (idx_ff != IDX_MAX) begin
            nxt_idx = idx_ff + IDX_FIRST_PARAM;
         end
         if (idx_ff == '0) begin
            nxt_cmd = link_rx_byte;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idx_ff <= '0;
         cmd_ff <= DUMMY_BYTE;
      end else begin
         idx_ff <= nxt_idx;
         cmd_ff <= nxt_cmd;
      end
   end

   // Answer byte: after byte n, prepare byte n+2, which is buffer entry n
   // Core has one byte time to do this, so the serial clock must not beat 12 ns
   always_comb begin
      nxt_rd_pend = byte_ev && !frame_idle && (cur_cmd == CMD_BUF_READ) && (idx_ff < len_ff);
      nxt_tx_hold = tx_hold_ff;
      if (frame_idle) begin
         nxt_tx_hold = DUMMY_BYTE;
      end else if (rd_pend_ff) begin
         nxt_tx_hold = mem_rdata;
      end else if (byte_ev) begin
         nxt_tx_hold = DUMMY_BYTE;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_pend_ff <= 1'b0;
         tx_hold_ff <= DUMMY_BYTE;
      end else begin
         rd_pend_ff <= nxt_rd_pend;
         tx_hold_ff <= nxt_tx_hold;
      end
   end

   // Copy engine from nonvolatile memory into the readout buffer
   always_comb begin
      nxt_st = st_ff;
      nxt_src = src_ff;
      nxt_cnt = cnt_ff;
      nxt_len = len_ff;
      mem_we = 1'b0;
      mem_waddr = cnt_ff[BUF_AW-1:0];
      mem_wdata = i_nvm_rd_data;
      unique case (st_ff)
         ST_IDLE: begin
         end
         ST_RD: begin
            nxt_st = ST_WAIT;
         end
         ST_WAIT: begin
            nxt_st = ST_WR;
         end
         ST_WR: begin
            mem_we = 1'b1;
            nxt_cnt = cnt_ff + IDX_FIRST_PARAM;
            nxt_st = (nxt_cnt == len_ff) ? ST_IDLE : ST_RD;
         end
      endcase
      // A crystal or config trigger restarts whatever copy is running; a channel trigger stops it
      if (is_first && link_rx_byte == CMD_XTAL_TRIG) begin
         nxt_src = NVM_XTAL_BASE + NVM_XTAL_FIRST;
         nxt_cnt = '0;
         nxt_len = XTAL_LEN;
         nxt_st = ST_RD;
      end else if (is_first && link_rx_byte == CMD_CONF_TRIG) begin
         nxt_src = NVM_CONF_BASE;
         nxt_cnt = '0;
         nxt_len = CONF_LEN;
         nxt_st = ST_RD;
      end else if (is_first && link_rx_byte == CMD_CHAN_TRIG) begin
         mem_we = 1'b1;
         mem_waddr = '0;
         mem_wdata = chan_state(i_cur_macro_channel, i_free_micro_channels);
         nxt_cnt = '0;
         nxt_len = CHAN_STATE_LEN;
         nxt_st = ST_IDLE;
      end
      nxt_nvm_rd = (st_ff == ST_RD);
      nxt_nvm_rd_addr = (st_ff == ST_RD) ? src_ff + NVM_AW'(cnt_ff) : o_nvm_rd_addr;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_ff <= ST_IDLE;
         src_ff <= '0;
         cnt_ff <= '0;
         len_ff <= '0;
         o_nvm_rd <= 1'b0;
         o_nvm_rd_addr <= '0;
      end else begin
         st_ff <= nxt_st;
         src_ff <= nxt_src;
         cnt_ff <= nxt_cnt;
         len_ff <= nxt_len;
         o_nvm_rd <= nxt_nvm_rd;
         o_nvm_rd_addr <= nxt_nvm_rd_addr;
      end
   end

   // Channel store parameters go straight to memory, one write per byte
   always_comb begin
      nxt_nvm_wr = 1'b0;
      nxt_nvm_wr_addr = o_nvm_wr_addr;
      nxt_nvm_wr_data = o_nvm_wr_data;
      chan_done = 1'b0;
      if (byte_ev && cmd_ff == CMD_CHAN_STORE && idx_ff != '0 && idx_ff <= CHAN_CFG_LEN) begin
         nxt_nvm_wr = 1'b1;
         nxt_nvm_wr_addr = NVM_CHAN_BASE + NVM_AW'(idx_ff - IDX_FIRST_PARAM);
         nxt_nvm_wr_data = link_rx_byte;
         chan_done = (idx_ff == CHAN_CFG_LEN);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_nvm_wr <= 1'b0;
         o_nvm_wr_addr <= '0;
         o_nvm_wr_data <= '0;
      end else begin
         o_nvm_wr <= nxt_nvm_wr;
         o_nvm_wr_addr <= nxt_nvm_wr_addr;
         o_nvm_wr_data <= nxt_nvm_wr_data;
      end
   end

   // Signal strength offset and corrected level
   always_comb begin
      nxt_offset = offset_ff;
      rssi_done = 1'b0;
      if (byte_ev && cmd_ff == CMD_RSSI_ADJ && idx_ff == IDX_FIRST_PARAM) begin
         nxt_offset = link_rx_byte;
         rssi_done = 1'b1;
      end
      nxt_rssi_system = sat_add(i_rssi_measured, offset_ff);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         offset_ff <= '0;
         o_rssi_system <= '0;
      end else begin
         offset_ff <= nxt_offset;
         o_rssi_system <= nxt_rssi_system;
      end
   end

   // Mode toggle, send gating, channel usage reset and completion event
   always_comb begin
      nxt_fixed = o_fixed_freq;
      if (is_first && link_rx_byte == CMD_FIXED_FREQ) begin
         nxt_fixed = ~o_fixed_freq;
      end
      nxt_send_frame = is_first && link_rx_byte == CMD_SEND && i_init_config_done;
      nxt_send_rx = is_first && link_rx_byte == CMD_SEND_RX && i_init_config_done;
      nxt_refused = is_first && !i_init_config_done
         && (link_rx_byte == CMD_SEND || link_rx_byte == CMD_SEND_RX);
      nxt_chan_reset = is_first && link_rx_byte == CMD_CHAN_RESET;
      // A completion arriving with the status read wins, so it is not lost
      ev_set = i_event_set || chan_done || rssi_done;
      ev_clr = is_first && link_rx_byte == CMD_STATUS;
      nxt_event = ev_set || (o_event && !ev_clr);
   end

   // Mode flag resets to hopping regardless of earlier toggling
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fixed_freq <= 1'b0;
         o_send_frame_req <= 1'b0;
         o_send_rx_req <= 1'b0;
         o_send_refused <= 1'b0;
         o_chan_usage_reset <= 1'b0;
         o_event <= 1'b0;
         started_ff <= 1'b0;
      end else begin
         o_fixed_freq <= nxt_fixed;
         o_send_frame_req <= nxt_send_frame;
         o_send_rx_req <= nxt_send_rx;
         o_send_refused <= nxt_refused;
         o_chan_usage_reset <= nxt_chan_reset;
         o_event <= nxt_event;
         started_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_hop_after_reset: assert property (!started_ff |-> !o_fixed_freq)
      else $error("fixed mode active right after reset");
   a_fixed_toggle_cmd: assert property ((is_first && link_rx_byte == CMD_FIXED_FREQ)
      |=> (o_fixed_freq != $past(o_fixed_freq)))
      else $error("fixed frequency command did not toggle mode");
   a_xtal_copy_len: assert property ((is_first && link_rx_byte == CMD_XTAL_TRIG)
      |-> ##[1:70] (st_ff == ST_IDLE && len_ff == XTAL_LEN && cnt_ff == XTAL_LEN))
      else $error("crystal table copy not completed with sixteen entries");
   a_conf_copy_len: assert property ((is_first && link_rx_byte == CMD_CONF_TRIG)
      |-> ##[1:45] (st_ff == ST_IDLE && cnt_ff == CONF_LEN))
      else $error("configuration copy not completed with ten bytes");
   // Entry zero written in the trigger cycle; the read port points at entry zero then too
   a_chan_state_load: assert property ((is_first && link_rx_byte == CMD_CHAN_TRIG)
      |-> (mem_we && mem_waddr == '0 && mem_wdata[3:0] == i_free_micro_channels
      && mem_wdata[7:4] == ((i_cur_macro_channel != DEFAULT_MACRO_CH) ? NIBBLE_ONES : NIBBLE_ZERO))
      ##1 (len_ff == CHAN_STATE_LEN))
      else $error("channel state byte not loaded into buffer");
   a_buf_read_data: assert property ((byte_ev && !frame_idle && cur_cmd == CMD_BUF_READ && idx_ff < len_ff)
      ##1 !frame_idle |=> (tx_hold_ff == $past(mem_rdata)))
      else $error("buffer read answer does not match buffer entry");
   a_dummy_at_idle: assert property (frame_idle |=> (tx_hold_ff == DUMMY_BYTE))
      else $error("answer byte not dummy outside frame");
   a_chan_store_write: assert property ((byte_ev && cmd_ff == CMD_CHAN_STORE && idx_ff == CHAN_CFG_LEN)
      |=> (o_nvm_wr && o_nvm_wr_addr == NVM_CHAN_BASE + NVM_AW'(CHAN_CFG_LEN - IDX_FIRST_PARAM) && o_event))
      else $error("last channel byte not written or no event");
   a_rssi_offset: assert property ((byte_ev && cmd_ff == CMD_RSSI_ADJ && idx_ff == IDX_FIRST_PARAM)
      |=> (offset_ff == $past(link_rx_byte))
      ##1 (o_rssi_system == sat_add($past(i_rssi_measured), offset_ff)))
      else $error("signal strength offset not applied");
   a_send_gated: assert property ((is_first && link_rx_byte == CMD_SEND && !i_init_config_done)
      |=> (!o_send_frame_req && o_send_refused))
      else $error("send accepted before configuration");
   a_status_clears: assert property ((ev_clr && !ev_set && o_event) |=> !o_event)
      else $error("status read did not clear event");
endmodule
`default_nettype wire

// ===== sim/crb_host.sv
// Host SPI master model for the command decoder
`timescale 1ns/100ps
`default_nettype none
module crb_host (
   input wire logic i_miso,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi
);
   logic [7:0] rx_q[$];
   // Serial clock stands still low outside frames
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // Mode 0 frame at a 12 ns period, MSB first, miso taken at each rise
   task automatic frame(input logic [7:0] tx[$]);
      logic [7:0] r;
      rx_q.delete();
      o_cs_n = 1'b0;
      #20;
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            o_mosi = tx[i][b];
            #6;
            r[b] = i_miso;
            o_sclk = 1'b1;
            #6;
            o_sclk = 1'b0;
         end
         rx_q.push_back(r);
      end
      #20;
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi; // Released line must not keep its last value
      #40;
   endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the configuration readback command decoder
`timescale 1ns/100ps
`default_nettype none
module tb import crb_pkg::*;;
   logic i_clk, i_reset_n, sclk, cs_n, mosi, miso, nrd, nwr, done, ev_set, fixed, ev;
   logic [7:0] raddr, waddr, wdata;
   logic [7:0] rdata = 8'h00;
   logic [3:0] cur, free;
   logic signed [7:0] meas, rsys, off;
   logic pf, prx, pref, prst;
   int cnt[4];
   int error_cnt, checks_done, seed, s;
   logic [7:0] nvm[256];
   logic [7:0] exq[$], st[$];
   logic [15:0] wq[$];
   crb_top dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_nvm_rd(nrd), .o_nvm_rd_addr(raddr),
      .i_nvm_rd_data(rdata), .o_nvm_wr(nwr), .o_nvm_wr_addr(waddr), .o_nvm_wr_data(wdata),
      .i_cur_macro_channel(cur), .i_free_micro_channels(free), .i_init_config_done(done),
      .i_rssi_measured(meas), .o_rssi_system(rsys), .o_fixed_freq(fixed), .o_send_frame_req(pf),
      .o_send_rx_req(prx), .o_send_refused(pref), .o_chan_usage_reset(prst),
      .i_event_set(ev_set), .o_event(ev));
   crb_host host_u (.i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Memory answers at the falling edge within its strobe cycle
   always @(negedge i_clk) if (nrd === 1'b1) rdata <= nvm[raddr];
   // Record writes and count one-cycle pulses
   always @(posedge i_clk) begin
      if (nwr === 1'b1) wq.push_back({waddr, wdata});
      if (pf === 1'b1) cnt[0]++;
      if (prx === 1'b1) cnt[1]++;
      if (pref === 1'b1) cnt[2]++;
      if (prst === 1'b1) cnt[3]++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic cmd(input logic [7:0] tx[$]);
      host_u.frame(tx);
      cyc(20);
   endtask
   // Buffer read: two filler bytes, then the expected contents
   task automatic readback(input logic [7:0] ex[$]);
      logic [7:0] tx[$];
      tx = '{CMD_BUF_READ, 8'h00};
      foreach (ex[i]) tx.push_back(8'h00);
      cmd(tx);
      chk(host_u.rx_q[0], DUMMY_BYTE);
      chk(host_u.rx_q[1], DUMMY_BYTE);
      foreach (ex[i]) chk(host_u.rx_q[i+2], ex[i]);
   endtask
   // Hang guard, counted as a mismatch
   initial begin
      #900000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      seed = 55;
      i_reset_n = 1'b0;
      {done, ev_set, meas} = '0;
      cur = 4'h1;
      free = 4'h0;
      foreach (nvm[i]) nvm[i] = 8'($random(seed));
      cyc(20);
      chk(fixed, 1'b0);
      i_reset_n = 1'b1;
      cyc(5);
      readback('{8'h00, 8'h00});
      cmd('{CMD_XTAL_TRIG});
      cyc(100);
      for (int k = 0; k < 16; k++) exq.push_back(nvm[2+k]);
      readback(exq);
      readback(exq);
      cmd('{CMD_CONF_TRIG});
      cyc(100);
      exq.delete();
      for (int k = 0; k < 10; k++) exq.push_back(nvm[8'h20+k]);
      readback(exq);
      // Default channel, then a changed one
      for (int k = 0; k < 2; k++) begin
         cur = (k == 0) ? 4'h1 : 4'($random(seed)) | 4'h2;
         free = 4'($random(seed));
         cmd('{CMD_CHAN_TRIG});
         readback('{{(cur != 4'h1) ? 4'hF : 4'h0, free}});
      end
      for (int k = 1; k <= 3; k++) begin
         cmd('{CMD_FIXED_FREQ});
         chk(fixed, k % 2);
      end
      // Mid-run reset while fixed mode is selected
      i_reset_n = 1'b0;
      cyc(3);
      i_reset_n = 1'b1;
      cyc(5);
      chk(fixed, 1'b0);
      st = '{CMD_CHAN_STORE, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      cmd(st);
      chk(wq.size(), 14);
      for (int k = 0; k < 14; k++) chk(wq[k], {NVM_CHAN_BASE + 8'(k), st[k+1]});
      chk(ev, 1'b1);
      cmd('{CMD_STATUS});
      chk(ev, 1'b0);
      ev_set = 1'b1;
      cyc(1);
      ev_set = 1'b0;
      cyc(3);
      chk(ev, 1'b1);
      cmd('{CMD_STATUS});
      chk(ev, 1'b0);
      // Offsets with both saturation corners first
      for (int k = 0; k < 6; k++) begin
         off = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : 8'($random(seed));
         cmd('{CMD_RSSI_ADJ, off});
         meas = (k < 2) ? off : 8'($random(seed));
         cyc(3);
         s = int'(meas) + int'(off);
         s = (s > 127) ? 127 : (s < -128) ? -128 : s;
         chk(rsys, 8'(s));
         chk(ev, 1'b1);
         cmd('{CMD_STATUS});
         chk(ev, 1'b0);
      end
      // Send and send-receive, refused then accepted
      for (int k = 0; k < 4; k++) begin
         done = k[1];
         cmd('{k[0] ? CMD_SEND_RX : CMD_SEND});
      end
      chk(cnt[2], 2);
      chk(cnt[0], 1);
      chk(cnt[1], 1);
      cmd('{CMD_CHAN_RESET});
      chk(cnt[3], 1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
